// >>> logic/urg_map.vh
`ifndef URG_MAP_VH
`define URG_MAP_VH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define URG_IDX_GRP    10'h084
`define URG_IDX_AGP    10'h085
`define URG_IDX_DUAL   10'h086
`define URG_IDX_STAT0  10'h087
`define URG_IDX_STAT1  10'h088
`define URG_RST_GRP    32'h0007_0007
`define URG_RST_AGP    32'h0008_0007
`define URG_RST_DUAL   32'h0000_0000
`define URG_MSK_GRP    32'hff17_7f17
`define URG_MSK_AGP    32'h00ff_7f1f
`define URG_MSK_DUAL   32'h0000_003f

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define URG_F_TEX_WM   2:0
`define URG_F_TEX_EN   4
`define URG_F_TEX_OPT  14:8
`define URG_F_ENG_WM   18:16
`define URG_F_ENG_URG  20
`define URG_F_ENG_OPT  30:24
`define URG_F_ENG_EN   31
`define URG_F_AGP_WM   2:0
`define URG_F_AGP_URG  3
`define URG_F_AGP_EN   4
`define URG_F_AGP_OPT  14:8
`define URG_F_AGP_TMR  23:16
`define URG_F_DUAL     0
`define URG_F_TAG      1
`define URG_F_DWACK    2
`define URG_F_RWACK    3
`define URG_F_FAST     4
`define URG_F_BYPASS   5
`define URG_OPT_RDY    0
`define URG_OPT_RE     1:0
`define URG_OPT_RE_PAT 2'b10
`define URG_OPT_TCOND  2
`define URG_OPT_FULL   3
`define URG_OPT_WM     4
`define URG_OPT_DIR    5
// active mode vector: dual, tag, dwack, rwack, fast, enables tex/eng/agp
`define URG_M_EN0      5
`define URG_RESP_OK    2'b00
`define URG_RESP_ERR   2'b10
`endif

// >>> logic/urg_path_ctl.v
`include "urg_map.vh"

module urg_path_ctl #(
  parameter AW       = 32,
  parameter ABW      = 12,
  parameter PW       = 3,
  parameter TMR_INIT = 8'h08
) (
  input  wire              i_clk_sys,
  input  wire              i_reset,
  input  wire [ABW-1:0]    i_s_axi_awaddr,
  input  wire              i_s_axi_awvalid,
  output wire              o_s_axi_awready,
  input  wire [31:0]       i_s_axi_wdata,
  input  wire [3:0]        i_s_axi_wstrb,
  input  wire              i_s_axi_wvalid,
  output wire              o_s_axi_wready,
  output wire [1:0]        o_s_axi_bresp,
  output wire              o_s_axi_bvalid,
  input  wire              i_s_axi_bready,
  input  wire [ABW-1:0]    i_s_axi_araddr,
  input  wire              i_s_axi_arvalid,
  output wire              o_s_axi_arready,
  output wire [31:0]       o_s_axi_rdata,
  output wire [1:0]        o_s_axi_rresp,
  output wire              o_s_axi_rvalid,
  input  wire              i_s_axi_rready,
  input  wire [2:0]        i_rd_valid,
  output wire [2:0]        o_rd_ready,
  input  wire [3*AW-1:0]   i_rd_addr,
  input  wire [2:0]        i_rd_wr,
  input  wire [2:0]        i_rd_urgent,
  input  wire [1:0]        i_w3d_valid,
  output wire [1:0]        o_w3d_ready,
  input  wire [2*AW-1:0]   i_w3d_addr,
  input  wire              i_ctl_idle,
  input  wire              i_ded_wr_issue,
  input  wire              i_hl_write_commit_ack_ded,
  input  wire              i_hl_write_commit_ack_rw,
  output wire              o_hl_valid,
  input  wire              i_hl_ready,
  output wire [AW-1:0]     o_hl_addr,
  output wire              o_hl_wr,
  output wire [2:0]        o_hl_client,
  output wire [3:0]        o_hl_group_len,
  output wire              o_hl_wch_path,
  output wire [7:0]        o_hl_tag,
  output wire [7:0]        o_ded_pending
);

  localparam DEPTH = 1 << PW;
  localparam PLW   = AW + 17;

  // ------------------------------------------------------------
  // register file and bus slave
  // ------------------------------------------------------------
  reg  [31:0]   grp_q, agp_q, dual_q;
  reg  [7:0]    act_q;
  reg           awr_q, wr_q, bv_q, arr_q, rv_q;
  reg  [1:0]    bresp_q, rresp_q;
  reg  [31:0]   rdata_q, wdat_q;
  reg  [3:0]    wstb_q;
  reg  [ABW-3:0] awi_q;
  reg           awf_q, wf_q;
  reg  [7:0]    ded_pend_q, wch_pend_q;
  wire [ABW-3:0] ari = i_s_axi_araddr[ABW-1:2];
  wire [3*(PW+1)-1:0] cnt_all;

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  stb;
    input [31:0] msk;
    integer b;
    begin
      wmerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (stb[b]) wmerge[b*8 +: 8] = dat[b*8 +: 8];
      end
      wmerge = wmerge & msk;
    end
  endfunction

  // write channel: address and data taken in any order, response after both
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      awr_q   <= 1'b1;
      wr_q    <= 1'b1;
      awf_q   <= 1'b0;
      wf_q    <= 1'b0;
      bv_q    <= 1'b0;
      bresp_q <= `URG_RESP_OK;
      awi_q   <= {(ABW-2){1'b0}};
      wdat_q  <= 32'h0000_0000;
      wstb_q  <= 4'h0;
      grp_q   <= `URG_RST_GRP;
      agp_q   <= `URG_RST_AGP;
      dual_q  <= `URG_RST_DUAL;
    end else begin
      if (i_s_axi_awvalid & awr_q) begin
        awi_q <= i_s_axi_awaddr[ABW-1:2];
        awf_q <= 1'b1;
        awr_q <= 1'b0;
      end
      if (i_s_axi_wvalid & wr_q) begin
        wdat_q <= i_s_axi_wdata;
        wstb_q <= i_s_axi_wstrb;
        wf_q   <= 1'b1;
        wr_q   <= 1'b0;
      end
      if (awf_q & wf_q & ~bv_q) begin
        bv_q    <= 1'b1;
        bresp_q <= `URG_RESP_OK;
        // shadow copies take the write at once and read back at once
        case (awi_q)
          `URG_IDX_GRP:  grp_q  <= wmerge(grp_q, wdat_q, wstb_q, `URG_MSK_GRP);
          `URG_IDX_AGP:  agp_q  <= wmerge(agp_q, wdat_q, wstb_q, `URG_MSK_AGP);
          `URG_IDX_DUAL: dual_q <= wmerge(dual_q, wdat_q, wstb_q, `URG_MSK_DUAL);
          `URG_IDX_STAT0, `URG_IDX_STAT1: bresp_q <= `URG_RESP_OK;
          default:       bresp_q <= `URG_RESP_ERR;
        endcase
      end
      if (bv_q & i_s_axi_bready) begin
        bv_q  <= 1'b0;
        awf_q <= 1'b0;
        wf_q  <= 1'b0;
        awr_q <= 1'b1;
        wr_q  <= 1'b1;
      end
    end
  end

  // read channel: one read at a time, data one cycle after the address
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      arr_q   <= 1'b1;
      rv_q    <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `URG_RESP_OK;
    end else if (i_s_axi_arvalid & arr_q) begin
      arr_q   <= 1'b0;
      rv_q    <= 1'b1;
      rresp_q <= `URG_RESP_OK;
      case (ari)
        `URG_IDX_GRP:   rdata_q <= grp_q;
        `URG_IDX_AGP:   rdata_q <= agp_q;
        `URG_IDX_DUAL:  rdata_q <= dual_q;
        `URG_IDX_STAT0: rdata_q <= {12'h000, act_q, cnt_all};
        `URG_IDX_STAT1: rdata_q <= {16'h0000, wch_pend_q, ded_pend_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `URG_RESP_ERR;
        end
      endcase
    end else if (rv_q & i_s_axi_rready) begin
      rv_q  <= 1'b0;
      arr_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // mode switch load
  // ------------------------------------------------------------
  wire [7:0] mode_sh = {agp_q[`URG_F_AGP_EN], grp_q[`URG_F_ENG_EN], grp_q[`URG_F_TEX_EN],
                        dual_q[`URG_F_FAST], dual_q[`URG_F_RWACK], dual_q[`URG_F_DWACK],
                        dual_q[`URG_F_TAG], dual_q[`URG_F_DUAL]};

  // active copies follow the shadow on bypass or on controller idle
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) act_q <= 8'h00;
    else if (dual_q[`URG_F_BYPASS] | i_ctl_idle) act_q <= mode_sh;
  end

  // per-grouper configuration; texture has no urgent eject
  wire [8:0]  cfg_wm  = {agp_q[`URG_F_AGP_WM], grp_q[`URG_F_ENG_WM], grp_q[`URG_F_TEX_WM]};
  wire [20:0] cfg_opt = {agp_q[`URG_F_AGP_OPT], grp_q[`URG_F_ENG_OPT], grp_q[`URG_F_TEX_OPT]};
  wire [2:0]  cfg_urg = {agp_q[`URG_F_AGP_URG], grp_q[`URG_F_ENG_URG], 1'b0};
  wire [23:0] cfg_tmr = {agp_q[`URG_F_AGP_TMR], TMR_INIT, TMR_INIT};

  // ------------------------------------------------------------
  // client groupers
  // ------------------------------------------------------------
  wire [4:0]       gnt;
  wire             buf_rdy;
  wire [2:0]       head_v;
  wire [3*AW-1:0]  head_a;
  wire [2:0]       head_w;
  wire [11:0]      head_l;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : grp
      reg  [AW-1:0]    addr_q [0:DEPTH-1];
      reg  [3:0]       len_q  [0:DEPTH-1];
      reg  [DEPTH-1:0] vld_q, dir_q, rdy_q, ejt_q;
      reg  [PW-1:0]    rp_q, wp_q;
      reg  [PW:0]      cnt_q;
      reg  [7:0]       tmr_q;
      reg              crdy_q;
      reg  [DEPTH-1:0] hit;
      reg  [PW-1:0]    hidx;
      integer          e;
      integer          c;
      wire [AW-1:0]    a    = i_rd_addr[g*AW +: AW];
      wire             w    = i_rd_wr[g];
      wire [6:0]       opt  = cfg_opt[g*7 +: 7];
      wire             en   = act_q[`URG_M_EN0+g];
      wire [PW:0]      wm2  = {cfg_wm[g*3 +: 3], 1'b0};
      wire             urg  = cfg_urg[g] & i_rd_urgent[g];
      wire [DEPTH-1:0] rp_oh = {{(DEPTH-1){1'b0}}, 1'b1} << rp_q;
      wire [DEPTH-1:0] wp_oh = {{(DEPTH-1){1'b0}}, 1'b1} << wp_q;
      wire [DEPTH-1:0] h_oh  = {{(DEPTH-1){1'b0}}, 1'b1} << hidx;
      wire             take    = i_rd_valid[g] & crdy_q;
      wire             grouped = take & en & (|hit);
      wire             alloc   = take & ~grouped;
      wire             tzero   = (tmr_q == 8'h00);
      wire             head    = vld_q[rp_q] & (ejt_q[rp_q] | tzero);
      wire             pop     = head & gnt[g];
      wire             all_ej  = ~en | (cnt_q > wm2) | (opt[`URG_OPT_FULL] & cnt_q[PW]) |
                                 (opt[`URG_OPT_WM] & (cnt_q >= wm2));
      wire [PW:0]      cnt_d   = cnt_q + {{PW{1'b0}}, alloc} - {{PW{1'b0}}, pop};

      // match search excludes the entry under the read pointer
      always @* begin
        hit  = {DEPTH{1'b0}};
        hidx = {PW{1'b0}};
        for (c = 0; c < DEPTH; c = c + 1) begin
          hit[c] = vld_q[c] & ~rp_oh[c] & (addr_q[c] == a) & (dir_q[c] == w) &
                   (~rdy_q[c] | opt[`URG_OPT_RDY] |
                    ((opt[`URG_OPT_RE] == `URG_OPT_RE_PAT) & ejt_q[c]));
        end
        for (c = DEPTH - 1; c >= 0; c = c - 1) begin
          if (hit[c]) hidx = c[PW-1:0];
        end
      end

      // entry state, pointers, occupancy and latency timer
      always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
          vld_q  <= {DEPTH{1'b0}};
          dir_q  <= {DEPTH{1'b0}};
          rdy_q  <= {DEPTH{1'b0}};
          ejt_q  <= {DEPTH{1'b0}};
          rp_q   <= {PW{1'b0}};
          wp_q   <= {PW{1'b0}};
          cnt_q  <= {(PW+1){1'b0}};
          tmr_q  <= 8'h00;
          crdy_q <= 1'b0;
          for (e = 0; e < DEPTH; e = e + 1) begin
            addr_q[e] <= {AW{1'b0}};
            len_q[e]  <= 4'h0;
          end
        end else begin
          for (e = 0; e < DEPTH; e = e + 1) begin
            if (vld_q[e] & (all_ej | (opt[`URG_OPT_DIR] & take & ~rdy_q[e] & (dir_q[e] != w))))
              ejt_q[e] <= 1'b1;
            if (vld_q[e] & rp_oh[e] & tzero) rdy_q[e] <= 1'b1;
            if (grouped & h_oh[e]) begin
              if (~&len_q[e]) len_q[e] <= len_q[e] + 4'h1;
              if (urg) ejt_q[e] <= 1'b1;
            end
            if (pop & rp_oh[e]) begin
              vld_q[e] <= 1'b0;
              rdy_q[e] <= 1'b0;
              ejt_q[e] <= 1'b0;
            end
            if (alloc & wp_oh[e]) begin
              vld_q[e]  <= 1'b1;
              addr_q[e] <= a;
              dir_q[e]  <= w;
              len_q[e]  <= 4'h1;
              rdy_q[e]  <= 1'b0;
              ejt_q[e]  <= urg | all_ej;
            end
          end
          if (alloc) wp_q <= wp_q + {{(PW-1){1'b0}}, 1'b1};
          if (pop)   rp_q <= rp_q + {{(PW-1){1'b0}}, 1'b1};
          cnt_q  <= cnt_d;
          crdy_q <= ~cnt_d[PW];
          if (pop | ~vld_q[rp_q])
            tmr_q <= cfg_tmr[g*8 +: 8];
          else if (~tzero & (~opt[`URG_OPT_TCOND] | (buf_rdy & ~head)))
            tmr_q <= tmr_q - 8'h01;
        end
      end

      assign o_rd_ready[g]              = crdy_q;
      assign head_v[g]                  = head;
      assign head_a[g*AW +: AW]         = addr_q[rp_q];
      assign head_w[g]                  = dir_q[rp_q];
      assign head_l[g*4 +: 4]           = len_q[rp_q];
      assign cnt_all[g*(PW+1) +: PW+1]  = cnt_q;
    end
  endgenerate

  // ------------------------------------------------------------
  // 3d write holding stages
  // ------------------------------------------------------------
  reg [1:0]      w3v_q, w3r_q;
  reg [2*AW-1:0] w3a_q;
  integer k;
  integer m;

  // one-entry stage per 3d write client
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      w3v_q <= 2'b00;
      w3r_q <= 2'b00;
      w3a_q <= {(2*AW){1'b0}};
    end else begin
      for (k = 0; k < 2; k = k + 1) begin
        if (i_w3d_valid[k] & w3r_q[k]) begin
          w3v_q[k]           <= 1'b1;
          w3r_q[k]           <= 1'b0;
          w3a_q[k*AW +: AW]  <= i_w3d_addr[k*AW +: AW];
        end else if (gnt[3+k] | ~w3v_q[k]) begin
          w3v_q[k] <= 1'b0;
          w3r_q[k] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // path steering, pacing and tagging
  // ------------------------------------------------------------
  reg            gap_q;
  reg  [7:0]     tag_q;
  reg  [PLW-1:0] pl;
  wire           pace_ok = act_q[`URG_F_FAST] | ~gap_q;
  wire [4:0]     req     = {w3v_q, head_v} & {5{buf_rdy & pace_ok}};
  assign         gnt     = req & (~req + 5'h01);
  wire           push    = |gnt;

  // payload of the granted source: tag, path, client, length, dir, addr
  always @* begin
    pl = {PLW{1'b0}};
    for (m = 0; m < 3; m = m + 1) begin
      if (gnt[m]) pl = {8'h00, 1'b0, m[2:0], head_l[m*4 +: 4], head_w[m], head_a[m*AW +: AW]};
    end
    for (m = 0; m < 2; m = m + 1) begin
      if (gnt[3+m]) pl = {8'h00, act_q[`URG_F_DUAL], m[2:0] + 3'h3, 4'h1, 1'b1,
                          w3a_q[m*AW +: AW]};
    end
    if (act_q[`URG_F_TAG]) pl[PLW-1 -: 8] = tag_q;
  end

  // issue gap and order tag counter
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      gap_q <= 1'b0;
      tag_q <= 8'h00;
    end else begin
      gap_q <= push & ~act_q[`URG_F_FAST];
      if (push & act_q[`URG_F_TAG]) tag_q <= tag_q + 8'h01;
    end
  end

  // uncommitted write counters; with dwack/rwack set, a same-cycle issue and ack leave the count unchanged
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ded_pend_q <= 8'h00;
      wch_pend_q <= 8'h00;
    end else begin
      if (i_ded_wr_issue & ~(act_q[`URG_F_DWACK] & i_hl_write_commit_ack_ded))
        ded_pend_q <= ded_pend_q + 8'h01;
      else if (~i_ded_wr_issue & act_q[`URG_F_DWACK] & i_hl_write_commit_ack_ded & (|ded_pend_q))
        ded_pend_q <= ded_pend_q - 8'h01;
      if (push & pl[AW+17-9] & ~(act_q[`URG_F_RWACK] & i_hl_write_commit_ack_rw))
        wch_pend_q <= wch_pend_q + 8'h01;
      else if (~(push & pl[AW+8]) & act_q[`URG_F_RWACK] & i_hl_write_commit_ack_rw & (|wch_pend_q))
        wch_pend_q <= wch_pend_q - 8'h01;
    end
  end

  // ------------------------------------------------------------
  // two-entry output buffer toward the host link
  // ------------------------------------------------------------
  reg           ov_q, sv_q;
  reg [PLW-1:0] od_q, sd_q;
  assign buf_rdy = ~sv_q;

  // output stage plus skid stage; a link stall fills the skid then stops grants
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ov_q <= 1'b0;
      sv_q <= 1'b0;
      od_q <= {PLW{1'b0}};
      sd_q <= {PLW{1'b0}};
    end else if (~ov_q | i_hl_ready) begin
      if (sv_q & (~ov_q | act_q[`URG_F_FAST])) begin
        od_q <= sd_q;
        ov_q <= 1'b1;
        sv_q <= 1'b0;
      end else if (sv_q) begin
        ov_q <= 1'b0;  // skid waits a cycle so the link keeps its 2-clock pace
      end else begin
        od_q <= pl;
        ov_q <= push;
      end
    end else if (push) begin
      sd_q <= pl;
      sv_q <= 1'b1;
    end
  end

  assign o_hl_valid      = ov_q;
  assign o_hl_addr       = od_q[AW-1:0];
  assign o_hl_wr         = od_q[AW];
  assign o_hl_group_len  = od_q[AW+4:AW+1];
  assign o_hl_client     = od_q[AW+7:AW+5];
  assign o_hl_wch_path   = od_q[AW+8];
  assign o_hl_tag        = od_q[PLW-1 -: 8];
  assign o_ded_pending   = ded_pend_q;
  assign o_w3d_ready     = w3r_q;
  assign o_s_axi_awready = awr_q;
  assign o_s_axi_wready  = wr_q;
  assign o_s_axi_bvalid  = bv_q;
  assign o_s_axi_bresp   = bresp_q;
  assign o_s_axi_arready = arr_q;
  assign o_s_axi_rvalid  = rv_q;
  assign o_s_axi_rdata   = rdata_q;
  assign o_s_axi_rresp   = rresp_q;

endmodule

// >>> sim/tb.sv
`include "urg_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys = 1'h0;
  logic        i_reset = 1'h1;
  logic [11:0] i_s_axi_awaddr = 12'h0, i_s_axi_araddr = 12'h0;
  logic [31:0] i_s_axi_wdata = 32'h0;
  logic [3:0]  i_s_axi_wstrb = 4'hf;
  logic        i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
  logic        i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
  logic        i_ctl_idle = 1'h0, i_ded_wr_issue = 1'h0, stall = 1'h0, dw_en = 1'h0;
  logic [4:0]  vld = 5'h0;
  logic [31:0] ad [5] = '{default: 32'h0};
  wire         o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  wire         o_s_axi_rvalid, o_hl_valid, i_hl_ready, o_hl_wr, o_hl_wch_path;
  wire         i_hl_write_commit_ack_ded, i_hl_write_commit_ack_rw;
  wire  [1:0]  o_s_axi_bresp, o_s_axi_rresp, o_w3d_ready;
  wire  [31:0] o_s_axi_rdata, o_hl_addr;
  wire  [2:0]  o_rd_ready, o_hl_client;
  wire  [3:0]  o_hl_group_len;
  wire  [7:0]  o_hl_tag, o_ded_pending;
  wire  [4:0]  rdy = {o_w3d_ready, o_rd_ready};
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  logic [63:0] hq [$];

  always #25 i_clk_sys = ~i_clk_sys;

  urg_path_ctl #(.TMR_INIT(8'h02)) u_dut (.i_clk_sys, .i_reset, .i_s_axi_awaddr,
    .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid,
    .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
    .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
    .i_s_axi_rready, .i_rd_valid(vld[2:0]), .o_rd_ready, .i_rd_addr({ad[2], ad[1], ad[0]}),
    .i_rd_wr(3'h0), .i_rd_urgent(3'h0), .i_w3d_valid(vld[4:3]), .o_w3d_ready,
    .i_w3d_addr({ad[4], ad[3]}), .i_ctl_idle, .i_ded_wr_issue, .i_hl_write_commit_ack_ded, .i_hl_write_commit_ack_rw,
    .o_hl_valid, .i_hl_ready, .o_hl_addr, .o_hl_wr, .o_hl_client, .o_hl_group_len,
    .o_hl_wch_path, .o_hl_tag, .o_ded_pending);

  urg_hl_model u_link (.i_clk_sys, .i_reset, .i_valid(o_hl_valid), .i_wr(o_hl_wr),
    .i_wch(o_hl_wch_path), .i_ded_issue(i_ded_wr_issue), .i_stall(stall), .i_dw_en(dw_en),
    .i_rw_en(1'h1), .o_ready(i_hl_ready), .o_write_commit_ack_ded(i_hl_write_commit_ack_ded), .o_write_commit_ack_rw(i_hl_write_commit_ack_rw));

  // ------------------------------------
  // monitor and shared tasks
  // ------------------------------------
  // log each accepted link request with its cycle
  always @(posedge i_clk_sys) begin
    cyc++;
    if (o_hl_valid && i_hl_ready)
      hq.push_back({o_hl_tag, cyc[15:0], o_hl_wch_path, o_hl_client, o_hl_group_len, o_hl_addr});
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic axi_wr(input logic [9:0] ix, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_s_axi_awaddr <= {ix, 2'h0};
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'h1;
    i_s_axi_wvalid <= 1'h1;
    i_s_axi_bready <= 1'h1;
    do begin
      @(posedge i_clk_sys);
      n++;
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
    end while (!o_s_axi_bvalid && n < 50);
    i_s_axi_bready <= 1'h0;
    chk("bvalid", {31'h0, o_s_axi_bvalid}, 32'h1);
    chk("bresp", {30'h0, o_s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rdx(input logic [9:0] ix, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_s_axi_araddr <= {ix, 2'h0};
    i_s_axi_arvalid <= 1'h1;
    i_s_axi_rready <= 1'h1;
    do begin
      @(posedge i_clk_sys);
      n++;
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
    end while (!o_s_axi_rvalid && n < 50);
    i_s_axi_rready <= 1'h0;
    chk("rvalid", {31'h0, o_s_axi_rvalid}, 32'h1);
    chk("rdata", o_s_axi_rdata, e);
    chk("rresp", {30'h0, o_s_axi_rresp}, {30'h0, er});
  endtask

  task automatic send(input int g, input logic [31:0] a);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    vld[g] <= 1'h1;
    ad[g] <= a;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (!rdy[g] && n < 100);
    vld[g] <= 1'h0;
    chk("client ready", {31'h0, rdy[g]}, 32'h1);
  endtask

  // fields: {wch path, client, group length}; t returns {tag, cycle}
  task automatic expq(input logic [31:0] a, input logic [7:0] f, output int t);
    int n;
    logic [63:0] e;
    n = 0;
    t = 0;
    while (hq.size() == 0 && n < 200) begin
      @(posedge i_clk_sys);
      n++;
    end
    chk("link count", {31'h0, hq.size() > 0}, 32'h1);
    if (hq.size() > 0) begin
      e = hq.pop_front();
      chk("link addr", e[31:0], a);
      chk("link fields", {24'h0, e[39:32]}, {24'h0, f});
      t = e[63:40];
    end
  endtask

  // ------------------------------------
  // scenarios
  // ------------------------------------
  task automatic t_regs;
    rdx(10'h084, 32'h0007_0007, 2'h0);
    rdx(10'h085, 32'h0008_0007, 2'h0);
    rdx(10'h086, 32'h0000_0000, 2'h0);
    axi_wr(10'h084, 32'hffff_ffff, 2'h0);
    rdx(10'h084, 32'hff17_7f17, 2'h0);
    axi_wr(10'h084, 32'h0007_0007, 2'h0);
    axi_wr(10'h085, 32'h00ab_0007, 2'h0);
    rdx(10'h085, 32'h00ab_0007, 2'h0);
    axi_wr(10'h3f0, 32'h0000_0001, 2'h2);
    rdx(10'h3f0, 32'h0000_0000, 2'h2);
    $display("test regs done");
  endtask

  task automatic t_bypass;
    int t;
    for (int g = 0; g < 5; g++) begin
      send(g, 32'h1000 * (g + 1));
      expq(32'h1000 * (g + 1), {1'h0, g[2:0], 4'h1}, t);
    end
    $display("test bypass done");
  endtask

  task automatic t_dual;
    int t;
    axi_wr(10'h086, 32'h0000_0001, 2'h0);
    rdx(10'h086, 32'h0000_0001, 2'h0);
    send(3, 32'h0000_5000);
    expq(32'h0000_5000, 8'h31, t);
    @(posedge i_clk_sys);
    i_ctl_idle <= 1'h1;
    @(posedge i_clk_sys);
    i_ctl_idle <= 1'h0;
    send(4, 32'h0000_6000);
    expq(32'h0000_6000, 8'hc1, t);
    send(0, 32'h0000_6100);
    expq(32'h0000_6100, 8'h01, t);
    axi_wr(10'h086, 32'h0000_0022, 2'h0);
    send(0, 32'h0000_c000);
    expq(32'h0000_c000, 8'h01, t);
    chk("order tag", t >> 16, 0);
    send(0, 32'h0000_c100);
    expq(32'h0000_c100, 8'h01, t);
    chk("order tag", t >> 16, 1);
    $display("test dual done");
  endtask

  task automatic t_fast(input logic [31:0] mode, input int gap);
    int t0, t1;
    axi_wr(10'h086, mode, 2'h0);
    stall <= 1'h1;
    send(0, 32'h0000_7000);
    send(1, 32'h0000_8000);
    repeat (6) @(posedge i_clk_sys);
    stall <= 1'h0;
    expq(32'h0000_7000, 8'h01, t0);
    expq(32'h0000_8000, 8'h11, t1);
    chk("issue gap", t1 - t0, gap);
    $display("test pacing gap %0d done", gap);
  endtask

  task automatic t_group;
    int t;
    axi_wr(10'h084, 32'h0007_0117, 2'h0);
    stall <= 1'h1;
    send(0, 32'h0000_a000);
    repeat (3) send(0, 32'h0000_b000);
    repeat (6) @(posedge i_clk_sys);
    stall <= 1'h0;
    expq(32'h0000_a000, 8'h01, t);
    expq(32'h0000_b000, 8'h01, t);
    expq(32'h0000_b000, 8'h02, t);
    axi_wr(10'h084, 32'h0007_0007, 2'h0);
    $display("test group done");
  endtask

  task automatic t_ack;
    axi_wr(10'h086, 32'h0000_0024, 2'h0);
    repeat (2) begin
      @(posedge i_clk_sys);
      i_ded_wr_issue <= 1'h1;
      @(posedge i_clk_sys);
      i_ded_wr_issue <= 1'h0;
    end
    @(posedge i_clk_sys);
    chk("ded pending", {24'h0, o_ded_pending}, 32'h2);
    dw_en <= 1'h1;
    @(posedge i_clk_sys);
    i_ded_wr_issue <= 1'h1;
    @(posedge i_clk_sys);
    i_ded_wr_issue <= 1'h0;
    repeat (3) @(posedge i_clk_sys);
    chk("ded pending", {24'h0, o_ded_pending}, 32'h2);
    $display("test ack done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // main sequence after a 12 cycle reset
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_reset <= 1'h0;
    repeat (2) @(posedge i_clk_sys);
    t_regs;
    t_bypass;
    t_dual;
    t_fast(32'h0000_0020, 2);
    t_fast(32'h0000_0030, 1);
    t_group;
    t_ack;
    close_out;
  end

  // watchdog far beyond the expected run length
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    error_cnt++;
    close_out;
  end
endmodule

// >>> sim/urg_hl_model.sv
module urg_hl_model (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  input  wire logic i_valid,
  input  wire logic i_wr,
  input  wire logic i_wch,
  input  wire logic i_ded_issue,
  input  wire logic i_stall,
  input  wire logic i_dw_en,
  input  wire logic i_rw_en,
  output logic      o_ready,
  output logic      o_write_commit_ack_ded,
  output logic      o_write_commit_ack_rw
);
  timeunit 1ns;
  timeprecision 1ps;
  // link side: ready drops while stalling, acks come one cycle late
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_ready <= 1'h0;
      o_write_commit_ack_ded <= 1'h0;
      o_write_commit_ack_rw <= 1'h0;
    end else begin
      o_ready <= !i_stall;
      o_write_commit_ack_ded <= i_dw_en && i_ded_issue;
      o_write_commit_ack_rw <= i_rw_en && i_valid && o_ready && i_wr && i_wch;
    end
  end
endmodule

// >>> sim/urg_path_ctl_assertions.sv
module urg_path_ctl_chk #(
  parameter AW = 32
) (
  input wire logic          i_clk_sys,
  input wire logic          i_reset,
  input wire logic          i_ded_wr_issue,
  input wire logic          i_hl_write_commit_ack_ded,
  input wire logic          i_hl_ready,
  input wire logic          o_hl_valid,
  input wire logic [AW-1:0] o_hl_addr,
  input wire logic [2:0]    o_hl_client,
  input wire logic [3:0]    o_hl_group_len,
  input wire logic          o_hl_wch_path,
  input wire logic [7:0]    o_hl_tag,
  input wire logic [7:0]    o_ded_pending
);
  default clocking dck @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // ------------------------------------
  // link request and pending counter
  // ------------------------------------
  a_req_hold: assert property (
    o_hl_valid && !i_hl_ready |=> o_hl_valid && $stable(o_hl_addr)
      && $stable({o_hl_client, o_hl_group_len, o_hl_wch_path, o_hl_tag}))
    else $error("link request changed while stalled");
  a_client_range: assert property (
    o_hl_valid |-> o_hl_client <= 3'h4) else $error("client code out of range");
  a_uma_path: assert property (
    o_hl_valid && o_hl_client < 3'h3 |-> !o_hl_wch_path) else $error("read client on write path");
  a_len_nonzero: assert property (
    o_hl_valid |-> o_hl_group_len != 4'h0) else $error("group length zero");
  a_ded_inc: assert property (
    i_ded_wr_issue && !i_hl_write_commit_ack_ded && o_ded_pending != 8'hff
      |=> o_ded_pending == $past(o_ded_pending) + 8'h01)
    else $error("pending count missed an issue");
  a_ded_hold: assert property (
    !i_ded_wr_issue && !i_hl_write_commit_ack_ded |=> $stable(o_ded_pending)) else $error("pending moved");
  a_ded_floor: assert property (
    o_ded_pending == 8'h00 && !i_ded_wr_issue |=> o_ded_pending == 8'h00)
    else $error("pending went below zero");
  a_ded_dec: assert property (
    i_hl_write_commit_ack_ded && !i_ded_wr_issue |=> o_ded_pending <= $past(o_ded_pending))
    else $error("ack raised pending count");
endmodule

bind urg_path_ctl urg_path_ctl_chk #(.AW(AW)) u_chk (.i_clk_sys, .i_reset, .i_ded_wr_issue,
  .i_hl_write_commit_ack_ded, .i_hl_ready, .o_hl_valid, .o_hl_addr, .o_hl_client, .o_hl_group_len,
  .o_hl_wch_path, .o_hl_tag, .o_ded_pending);
